// file: include/enc_mute_pkg.sv
/*
  Constants for the encoder diagnostic muting block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 25 MHz clock and a classic Wishbone slave with 32-bit data.
*/
`default_nettype none
package enc_mute_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned EDGE_WINDOW_MS = 2000;
  localparam int unsigned PERIOD_MIN_MS = 100;
  localparam int unsigned PERIOD_MAX_MS = 25000;
  localparam logic [15:0] PERIOD_RST = 16'h0064;
  localparam int unsigned NUM_AXES = 2;
  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PERIOD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_MEAS_LEN = 8'h14;
  localparam logic [7:0] REG_PRESET = 8'h18;
  localparam logic [7:0] REG_POS = 8'h1C;
  // Control fields
  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_MODE = 1;
  localparam int unsigned CTRL_AXIS = 2;
  localparam int unsigned CTRL_SUP_PERM = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // Status and interrupt fields
  localparam int unsigned ST_MUTE = 0;
  localparam int unsigned ST_ARMED = 1;
  localparam int unsigned ST_RUN = 2;
  localparam int unsigned ST_SUP = 3;
  localparam int unsigned EV_MUTE_START = 0;
  localparam int unsigned EV_MUTE_END = 1;
  localparam int unsigned EV_PERIOD_REJ = 2;
  localparam int unsigned EV_PRESET_REJ = 3;
  localparam int unsigned EV_ALARM = 4;
  localparam int unsigned EV_ENC_FLAG = 5;
  localparam int unsigned EV_W = 6;
  localparam logic [31:0] MEAS_LEN_RST = 32'h0000FFFF;
  typedef enum logic [1:0] {
    ARM_IDLE = 2'b00,
    ARM_LOW = 2'b01,
    ARM_READY = 2'b10
  } arm_state_e;
endpackage : enc_mute_pkg
`default_nettype wire

// file: hw/enc_mute.sv
/*
  Encoder diagnostic muting: a timed suppressor of the two-channel
  plausibility test and an encoder status supervision element, with a
  Wishbone register file and one level interrupt.
  Assumes encoder fault inputs come from another clock domain or pins and
  are synchronised here; activation input is a pin.
*/
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module enc_mute
  import enc_mute_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Encoder side, asynchronous
  input wire logic mute_request_n,
  input wire logic [NUM_AXES-1:0] position_deviation_alarm,
  input wire logic [NUM_AXES-1:0] speed_deviation_alarm,
  input wire logic [NUM_AXES-1:0] encoder_fault,
  input wire logic supervision_enable,
  // Results
  output logic [NUM_AXES-1:0] plausibility_suppress,
  output logic position_deviation_muting,
  output logic encoder_status_supervision,
  output logic encoder_error,
  output logic alarm_e_prefix,
  output logic outputs_blocked,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int unsigned SW = 2 + 3 * NUM_AXES;
  // Request bit resets to the pin's idle high level, so no false fall follows reset
  localparam logic [SW-1:0] SYNC_RST = {1'b0, 1'b1, {(SW-2){1'b0}}};
  logic [SW-1:0] sync1_q, sync2_q;
  logic [SW-1:0] raw_in;
  assign raw_in = {supervision_enable, mute_request_n, encoder_fault,
                   speed_deviation_alarm, position_deviation_alarm};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end
  logic [NUM_AXES-1:0] pos_alarm_s, spd_alarm_s, enc_fault_s;
  logic req_s, sup_en_s;
  assign pos_alarm_s = sync2_q[NUM_AXES-1:0];
  assign spd_alarm_s = sync2_q[2*NUM_AXES-1:NUM_AXES];
  assign enc_fault_s = sync2_q[3*NUM_AXES-1:2*NUM_AXES];
  assign req_s = sync2_q[SW-2];
  assign sup_en_s = sync2_q[SW-1];

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  logic [14:0] div_q, div_d;
  logic tick;
  // One-cycle enable every millisecond
  assign tick = (div_q == 15'(TICK_CYC - 1));
  always_comb begin
    div_d = tick ? 15'h0000 : div_q + 15'h0001;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) div_q <= 15'h0000;
    else div_q <= div_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus
  logic [3:0] ctrl_q, ctrl_d;
  logic [15:0] period_q, period_d;
  logic [EV_W-1:0] ist_q, ist_d, imask_q, imask_d, ev, ev_bus;
  logic [31:0] meas_len_q, meas_len_d, pos_q, pos_d;
  logic [31:0] rdata_d;
  logic ack_d, wr, rd_ok;
  logic [31:0] wmask;
  logic [3:0] status;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  logic [31:0] wval;
  always_comb begin
    wval = 32'h0;
    case (wb_adr_i)
      REG_CTRL: wval = {28'h0, ctrl_q};
      REG_PERIOD: wval = {16'h0, period_q};
      REG_MEAS_LEN: wval = meas_len_q;
      REG_PRESET: wval = pos_q;
      default: wval = 32'h0;
    endcase
    wval = (wval & ~wmask) | (wb_dat_i & wmask);
  end
  logic period_ok, preset_ok;
  assign period_ok = (wval[31:16] == 16'h0) && (wval[15:0] >= 16'(PERIOD_MIN_MS))
                     && (wval[15:0] <= 16'(PERIOD_MAX_MS));
  assign preset_ok = (wval != 32'h0) && (wval < meas_len_q);
  always_comb begin
    ctrl_d = ctrl_q;
    period_d = period_q;
    meas_len_d = meas_len_q;
    pos_d = pos_q;
    imask_d = imask_q;
    ev_bus = {EV_W{1'b0}};
    if (wr) begin
      case (wb_adr_i)
        REG_CTRL: ctrl_d = wval[3:0];
        REG_PERIOD: begin
          if (period_ok) period_d = wval[15:0];
          else ev_bus[EV_PERIOD_REJ] = 1'b1;
        end
        REG_MEAS_LEN: meas_len_d = wval;
        REG_PRESET: begin
          if (preset_ok) pos_d = wval;
          else ev_bus[EV_PRESET_REJ] = 1'b1;
        end
        REG_IRQ_MASK: imask_d = wval[EV_W-1:0];
        default: ;
      endcase
    end
    rd_ok = 1'b1;
    case (wb_adr_i)
      REG_CTRL: rdata_d = {28'h0, ctrl_q};
      REG_PERIOD: rdata_d = {16'h0, period_q};
      REG_STATUS: rdata_d = {24'h0, 2'(NUM_AXES), enc_fault_s, status};
      REG_IRQ_STAT: rdata_d = {{(32-EV_W){1'b0}}, ist_q};
      REG_IRQ_MASK: rdata_d = {{(32-EV_W){1'b0}}, imask_q};
      REG_MEAS_LEN: rdata_d = meas_len_q;
      REG_PRESET: rdata_d = pos_q;
      REG_POS: rdata_d = pos_q;
      default: begin
        rdata_d = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
    ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
      period_q <= PERIOD_RST;
      meas_len_q <= MEAS_LEN_RST;
      pos_q <= 32'h0;
      imask_q <= {EV_W{1'b0}};
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      period_q <= period_d;
      meas_len_q <= meas_len_d;
      pos_q <= pos_d;
      imask_q <= imask_d;
      // Read data is zero outside the acknowledge cycle
      wb_dat_o <= (ack_d && rd_ok) ? rdata_d : 32'h0;
      wb_ack_o <= ack_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activation edge pair monitor
  arm_state_e arm_q, arm_d;
  logic [10:0] win_q, win_d;
  logic req_q;
  logic armed;
  logic [15:0] cnt_q, cnt_d;
  logic mute_q, mute_d, start;
  logic axis_alarm;
  assign axis_alarm = pos_alarm_s[ctrl_q[CTRL_AXIS]];
  always_comb begin
    arm_d = arm_q;
    win_d = win_q;
    armed = 1'b0;
    case (arm_q)
      ARM_IDLE: begin
        if (req_q && !req_s && ctrl_q[CTRL_ENABLE]) begin
          arm_d = ARM_LOW;
          win_d = 11'h000;
        end
      end
      ARM_LOW: begin
        if (tick) win_d = win_q + 11'h001;
        if (win_q >= 11'(EDGE_WINDOW_MS)) arm_d = ARM_IDLE;
        else if (req_s) arm_d = ARM_READY;
      end
      // Armed waits for the start condition or a disable
      ARM_READY: begin
        armed = 1'b1;
        if (mute_q || !ctrl_q[CTRL_ENABLE]) arm_d = ARM_IDLE;
      end
      default: arm_d = ARM_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Muting timer
  always_comb begin
    start = armed && !mute_q && (ctrl_q[CTRL_MODE] || axis_alarm);
    mute_d = mute_q;
    cnt_d = cnt_q;
    if (start) begin
      mute_d = 1'b1;
      cnt_d = period_q;
    end else if (mute_q && tick) begin
      if (cnt_q <= 16'h0001) begin
        mute_d = 1'b0;
        cnt_d = 16'h0000;
      end else cnt_d = cnt_q - 16'h0001;
    end
    if (!ctrl_q[CTRL_ENABLE]) mute_d = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supervision and run state
  logic sup, run_q, run_d, fault_any;
  assign sup = ctrl_q[CTRL_SUP_PERM] || sup_en_s;
  assign fault_any = |(enc_fault_s | spd_alarm_s | (pos_alarm_s & ~plausibility_mask()));
  function automatic logic [NUM_AXES-1:0] plausibility_mask();
    // Next muting state, so the alarm that starts muting cannot trip run
    plausibility_mask = mute_d ? (NUM_AXES'(1) << ctrl_q[CTRL_AXIS]) : {NUM_AXES{1'b0}};
  endfunction : plausibility_mask
  always_comb begin
    run_d = run_q;
    // Run falls once and stays down until reset
    if (fault_any && !sup && !(mute_d && !(|enc_fault_s))) run_d = 1'b0;
    // Supervision freezes the run state
    if (sup) run_d = run_q;
  end
  assign status = {sup, run_q, armed, mute_q};
  always_comb begin
    ev = ev_bus;
    ev[EV_MUTE_START] = start;
    ev[EV_MUTE_END] = mute_q && !mute_d;
    ev[EV_ALARM] = run_q && !run_d;
    ev[EV_ENC_FLAG] = sup && fault_any;
    ist_d = ist_q;
    // An event wins over a clear in the same cycle
    if (wr && wb_adr_i == REG_IRQ_STAT) ist_d = ist_q & ~(wb_dat_i[EV_W-1:0]);
    ist_d = ist_d | ev;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arm_q <= ARM_IDLE;
      win_q <= 11'h000;
      req_q <= 1'b1;
      cnt_q <= 16'h0000;
      mute_q <= 1'b0;
      run_q <= 1'b1;
      ist_q <= {EV_W{1'b0}};
      plausibility_suppress <= {NUM_AXES{1'b0}};
      position_deviation_muting <= 1'b0;
      encoder_status_supervision <= 1'b0;
      encoder_error <= 1'b0;
      alarm_e_prefix <= 1'b0;
      outputs_blocked <= 1'b0;
      irq <= 1'b0;
    end else begin
      arm_q <= arm_d;
      win_q <= win_d;
      req_q <= req_s;
      cnt_q <= cnt_d;
      mute_q <= mute_d;
      run_q <= run_d;
      ist_q <= ist_d;
      plausibility_suppress <= mute_d ? (NUM_AXES'(1) << ctrl_q[CTRL_AXIS]) : {NUM_AXES{1'b0}};
      position_deviation_muting <= mute_d;
      encoder_status_supervision <= sup;
      encoder_error <= sup && fault_any;
      alarm_e_prefix <= sup && fault_any;
      outputs_blocked <= !run_d;
      irq <= |(ist_d & imask_q);
    end
  end
endmodule : enc_mute
`default_nettype wire

// file: verification/enc_mute_monitor.sv
/*
  Port checker for enc_mute: bus handshake, muting output and supervision.
  Assumes one clock domain and the async active-low reset rstn.
*/
`timescale 1ns/100ps
`default_nettype none
module enc_mute_monitor
  import enc_mute_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Results
  input wire logic [NUM_AXES-1:0] plausibility_suppress,
  input wire logic position_deviation_muting,
  input wire logic encoder_status_supervision,
  input wire logic encoder_error,
  input wire logic alarm_e_prefix,
  input wire logic outputs_blocked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_rdata_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_mute_output_level: assert property (position_deviation_muting == (|plausibility_suppress))
    else $error("muting output disagrees with suppression");
  chk_single_axis_mute: assert property ($onehot0(plausibility_suppress))
    else $error("more than one axis suppressed");
  chk_prefix_tracks_err: assert property (alarm_e_prefix == encoder_error)
    else $error("prefix flag differs from encoder error");
  chk_err_needs_sup: assert property (encoder_error |-> encoder_status_supervision)
    else $error("encoder error shown without supervision");
  chk_block_latched: assert property (outputs_blocked |=> outputs_blocked)
    else $error("output block released before reset");
endmodule : enc_mute_monitor
bind enc_mute enc_mute_monitor enc_mute_monitor_i (.clk, .rstn, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .plausibility_suppress, .position_deviation_muting,
  .encoder_status_supervision, .encoder_error, .alarm_e_prefix, .outputs_blocked);
`default_nettype wire

// file: verification/enc_side_model.sv
/*
  Activation source model: holds the request pin high and, on go, makes
  one low pulse of ten cycles, well inside the edge-pair window.
  Assumes go is a one-cycle strobe from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module enc_side_model (
  // Clock and command
  input wire logic clk,
  input wire logic go,
  // Pin
  output logic mute_request_n
);
  logic [3:0] low_q = 4'h0;
  always_ff @(posedge clk) begin
    low_q <= go ? 4'hA : (low_q != 4'h0 ? low_q - 4'h1 : low_q);
  end
  assign mute_request_n = (low_q == 4'h0);
endmodule : enc_side_model
`default_nettype wire

// file: verification/encoder_diagnostic_muting_tb.sv
/*
  Self-checking bench for enc_mute: registers, rejects, interrupt, muting
  modes and supervision.
  Assumes the 25 MHz clock; the 100 ms period is never waited out.
*/
`timescale 1ns/100ps
`default_nettype none
module encoder_diagnostic_muting_tb
  import enc_mute_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, go = 1'b0;
  logic supervision_enable = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, mute_request_n, position_deviation_muting, encoder_status_supervision;
  logic encoder_error, alarm_e_prefix, outputs_blocked, irq;
  logic [NUM_AXES-1:0] position_deviation_alarm = 2'h0, speed_deviation_alarm = 2'h0;
  logic [NUM_AXES-1:0] encoder_fault = 2'h0, plausibility_suppress;
  int error_cnt = 0, checks = 0;
  enc_mute enc_mute_i (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .mute_request_n, .position_deviation_alarm,
    .speed_deviation_alarm, .encoder_fault, .supervision_enable, .plausibility_suppress,
    .position_deviation_muting, .encoder_status_supervision, .encoder_error,
    .alarm_e_prefix, .outputs_blocked, .irq);
  enc_side_model enc_side_model_i (.clk, .go, .mute_request_n);
  initial forever #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    @(negedge clk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk("read data", q, exp);
  endtask : rd
  task rst;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
  endtask : rst
  task arm_and_wait;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (40) @(negedge clk);
  endtask : arm_and_wait
  ////////////////////////////////////////////////////////////////////////////
  task t_regs_and_rejects;
    rst();
    rd(REG_CTRL, 32'h0);
    rd(REG_MEAS_LEN, MEAS_LEN_RST);
    rd(8'h20, 32'h0);
    wr(REG_PERIOD, 32'd99);
    wr(REG_PERIOD, 32'd25001);
    rd(REG_PERIOD, 32'd100);
    wr(REG_PERIOD, 32'd25000);
    rd(REG_PERIOD, 32'd25000);
    rd(REG_IRQ_STAT, 32'h4);
    chk("irq masked", irq, 1'b0);
    wr(REG_IRQ_MASK, 32'h4);
    chk("irq raised", irq, 1'b1);
    wr(REG_IRQ_STAT, 32'h4);
    chk("irq cleared", irq, 1'b0);
    wr(REG_PRESET, 32'h0);
    rd(REG_IRQ_STAT, 32'h8);
    wr(REG_IRQ_STAT, 32'h8);
    wr(REG_PRESET, 32'h10);
    wr(REG_PRESET, MEAS_LEN_RST);
    rd(REG_IRQ_STAT, 32'h8);
    rd(REG_POS, 32'h10);
  endtask : t_regs_and_rejects
  task t_adjust_mode;
    rst();
    wr(REG_CTRL, 32'h3);
    chk("muting before edges", position_deviation_muting, 1'b0);
    arm_and_wait();
    chk("muting adjust", position_deviation_muting, 1'b1);
    chk("suppress axis0", plausibility_suppress, 2'b01);
  endtask : t_adjust_mode
  task t_alarm_mode;
    rst();
    wr(REG_CTRL, 32'h5);
    arm_and_wait();
    chk("muting without alarm", position_deviation_muting, 1'b0);
    @(posedge clk);
    position_deviation_alarm <= 2'b10;
    repeat (20) @(negedge clk);
    chk("suppress axis1", plausibility_suppress, 2'b10);
    chk("run kept while muted", outputs_blocked, 1'b0);
    @(posedge clk);
    position_deviation_alarm <= 2'b00;
  endtask : t_alarm_mode
  task t_supervision;
    rst();
    wr(REG_CTRL, 32'h8);
    @(posedge clk);
    speed_deviation_alarm <= 2'b01;
    encoder_fault <= 2'b01;
    repeat (10) @(negedge clk);
    chk("supervision on", encoder_status_supervision, 1'b1);
    chk("error shown", encoder_error, 1'b1);
    chk("prefix", alarm_e_prefix, 1'b1);
    chk("stays run", outputs_blocked, 1'b0);
    rd(REG_STATUS, 32'h9C);
    rst();
    repeat (10) @(negedge clk);
    chk("blocked", outputs_blocked, 1'b1);
    @(posedge clk);
    speed_deviation_alarm <= 2'b00;
    encoder_fault <= 2'b10;
    supervision_enable <= 1'b1;
    rst();
    repeat (10) @(negedge clk);
    chk("dynamic enable", encoder_error, 1'b1);
    chk("dynamic stays run", outputs_blocked, 1'b0);
  endtask : t_supervision
  initial begin
    repeat (8000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    t_regs_and_rejects();
    t_adjust_mode();
    t_alarm_mode();
    t_supervision();
    tally_and_finish();
  end
endmodule : encoder_diagnostic_muting_tb
`default_nettype wire
